// file: sim/bls_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module bls_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Device request
  input  wire logic       host_shutdown_req,
  // Observed activity
  output logic [7:0]      shutdown_starts
);
  logic prev_req_ff;

  initial begin
    prev_req_ff     = 1'b0;
    shutdown_starts = 8'h00;
  end

  // Host begins its own shutdown once per new request
  always @(posedge sys_clk) begin
    if (host_shutdown_req === 1'b1 && prev_req_ff === 1'b0) begin
      shutdown_starts <= shutdown_starts + 8'h01;
    end
    prev_req_ff <= host_shutdown_req;
  end
endmodule : bls_host_model

`default_nettype wire

// file: sim/bls_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none

module bls_sequencer_checker (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  // Register access
  input wire bls_pkg::bls_reg_req_type reg_req,
  input wire logic                     reg_ack,
  // Field side
  input wire bls_pkg::bls_sense_type   sense,
  input wire logic                     permanent_out_on,
  input wire logic                     dynamic_out_on,
  input wire logic                     backup_active,
  input wire logic                     host_shutdown_req,
  input wire logic                     device_off,
  input wire bls_pkg::bls_state_type   seq_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_ack_follows: assert property (reg_ack == $past(reg_req.wr || reg_req.rd))
    else $error("ack not one cycle after request");
  chk_load_off_cmd: assert property (reg_req.wr && reg_req.wdata ==
    bls_pkg::LOAD_OFF_CMD && reg_req.addr == bls_pkg::LOAD_SHUTDOWN_COMMAND_OFS
    |=> ##1 !dynamic_out_on [*3])
    else $error("dynamic output still on after load off");
  chk_perm_out_on: assert property ($past(rst_n) &&
    $past(seq_state) == bls_pkg::ST_NORMAL |-> permanent_out_on)
    else $error("permanent output off in normal state");
  chk_mains_loss: assert property (seq_state == bls_pkg::ST_NORMAL &&
    !sense.mains_ok |=> seq_state != bls_pkg::ST_NORMAL)
    else $error("no reaction to mains loss");
  chk_mains_back: assert property (seq_state == bls_pkg::ST_BUFFER &&
    sense.mains_ok |=> seq_state == bls_pkg::ST_NORMAL)
    else $error("buffering not abandoned on mains return");
  chk_backup_flag: assert property (seq_state == bls_pkg::ST_BUFFER
    |=> backup_active)
    else $error("backup flag low while buffering");
  chk_host_request: assert property (seq_state == bls_pkg::ST_HOSTSD
    |=> host_shutdown_req)
    else $error("host request low in step two");
  chk_step_two_hold: assert property (seq_state == bls_pkg::ST_HOSTSD |=>
    seq_state inside {bls_pkg::ST_HOSTSD, bls_pkg::ST_OUTOFF,
    bls_pkg::ST_POWEROFF})
    else $error("step two interrupted");
  chk_cutoff_off: assert property (!sense.mains_ok && sense.cutoff &&
    seq_state != bls_pkg::ST_POWEROFF |=> seq_state == bls_pkg::ST_POWEROFF
    ##1 device_off)
    else $error("no power off at cutoff");
  chk_step_four: assert property (seq_state == bls_pkg::ST_STEP4 |=>
    seq_state inside {bls_pkg::ST_NORMAL, bls_pkg::ST_POWEROFF})
    else $error("step four not left at once");

  cov_buffer: cover property (seq_state == bls_pkg::ST_BUFFER);
  cov_hostsd: cover property (seq_state == bls_pkg::ST_HOSTSD);
  cov_poweroff: cover property (seq_state == bls_pkg::ST_POWEROFF);
endmodule : bls_sequencer_checker

bind bls_sequencer bls_sequencer_checker i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_ack(reg_ack),
  .sense(sense), .permanent_out_on(permanent_out_on),
  .dynamic_out_on(dynamic_out_on), .backup_active(backup_active),
  .host_shutdown_req(host_shutdown_req), .device_off(device_off),
  .seq_state(seq_state)
);

`default_nettype wire

// file: sim/test_backup_load_shutdown_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module test_backup_load_shutdown_sequencer;
  logic                     sys_clk;
  logic                     rst_n;
  bls_pkg::bls_reg_req_type reg_req;
  bls_pkg::bls_sense_type   sense;
  logic                     dyn_out_cmd;
  logic [15:0]              reg_rdata;
  logic                     reg_ack;
  logic                     permanent_out_on;
  logic                     dynamic_out_on;
  logic                     backup_active;
  logic                     fast_charge_en;
  logic                     host_shutdown_req;
  logic                     device_off;
  logic                     diagnostic_indicator;
  bls_pkg::bls_state_type   seq_state;
  logic [7:0]               host_starts;
  int                       n_mismatch;
  int                       checked;
  int                       cycles;
  // Reset table, last entry unmapped
  logic [15:0] ofs_tbl [8] = '{16'h9c62, 16'h9c69, 16'h9c98, 16'h9ca8,
                               16'h9caf, 16'h9cc5, 16'h9cc7, 16'h9c63};
  logic [15:0] rst_tbl [8] = '{16'h0014, 16'h0000, 16'h0000, 16'h0000,
                               16'h003c, 16'h0000, 16'h0000, 16'h0000};
  logic [5:0]  cause_tbl [4] = '{6'h10, 6'h0c, 6'h08, 6'h02};
  bls_pkg::bls_state_type trip_tbl [4] = '{bls_pkg::ST_HOSTSD,
    bls_pkg::ST_HOSTSD, bls_pkg::ST_BUFFER, bls_pkg::ST_POWEROFF};

  bls_sequencer i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .sense(sense),
    .buffer_selector(4'h0), .selector_fitted(1'b0),
    .dyn_out_cmd(dyn_out_cmd), .permanent_out_on(permanent_out_on),
    .dynamic_out_on(dynamic_out_on), .backup_active(backup_active),
    .fast_charge_en(fast_charge_en), .host_shutdown_req(host_shutdown_req),
    .device_off(device_off), .diagnostic_indicator(diagnostic_indicator),
    .seq_state(seq_state)
  );

  bls_host_model i_host (
    .sys_clk(sys_clk), .host_shutdown_req(host_shutdown_req),
    .shutdown_starts(host_starts)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // One-cycle strobe, then a free cycle so strobes never merge
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [15:0] d);
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    tick(1);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    check("reg_ack", 16'h0001, {15'h0000, reg_ack});
    tick(1);
  endtask : access

  task automatic rd_chk(input string n, input logic [15:0] a,
                        input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    check(n, exp, reg_rdata);
  endtask : rd_chk

  task automatic trip(input logic [5:0] s, input bls_pkg::bls_state_type st);
    sense = s;
    tick(3);
    check("seq_state", {10'h000, st}, {10'h000, seq_state});
  endtask : trip

  task automatic do_reset;
    rst_n = 1'b0;
    sense = 6'h20;
    tick(4);
    rst_n = 1'b1;
    tick(2);
  endtask : do_reset

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("[ERR] run expected done seen timeout");
      end_of_test();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    sense = 6'h20;
    dyn_out_cmd = 1'b1;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    do_reset();
    check("permanent_out_on", 16'h0001, {15'h0000, permanent_out_on});
    check("dynamic_out_on", 16'h0001, {15'h0000, dynamic_out_on});
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", ofs_tbl[i], rst_tbl[i]);
    end
    access(1'b1, 16'h9cc5, 16'h7d01);
    rd_chk("load command", 16'h9cc5, 16'h0001);
    check("dynamic_out_on", 16'h0000, {15'h0000, dynamic_out_on});
    check("diagnostic_indicator", 16'h0000,
          {15'h0000, diagnostic_indicator});
    access(1'b1, 16'h9cc5, 16'h1234);
    rd_chk("load command", 16'h9cc5, 16'h0001);
    access(1'b1, 16'h9cc5, 16'h7d00);
    rd_chk("load command", 16'h9cc5, 16'h0000);
    tick(2);
    check("dynamic_out_on", 16'h0001, {15'h0000, dynamic_out_on});
    access(1'b1, 16'h9ca8, 16'h0064);
    rd_chk("buffering time", 16'h9ca8, 16'h0064);
    trip(6'h00, bls_pkg::ST_BUFFER);
    check("backup_active", 16'h0001, {15'h0000, backup_active});
    trip(6'h20, bls_pkg::ST_NORMAL);
    trip(6'h00, bls_pkg::ST_BUFFER);
    access(1'b1, 16'h9c69, 16'h0001);
    tick(2);
    check("seq_state", 16'h0004, {10'h000, seq_state});
    check("host request", 16'h0001, {15'h0000, host_shutdown_req});
    check("host starts", 16'h0001, {8'h00, host_starts});
    trip(6'h20, bls_pkg::ST_HOSTSD);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      trip(6'h00, bls_pkg::ST_BUFFER);
      trip(cause_tbl[i], trip_tbl[i]);
    end
    do_reset();
    sense = 6'h21;
    tick(1);
    check("fast_charge_en", 16'h0001, {15'h0000, fast_charge_en});
    access(1'b1, 16'h9c98, 16'h0001);
    check("fast_charge_en", 16'h0000, {15'h0000, fast_charge_en});
    trip(6'h01, bls_pkg::ST_BUFFER);
    trip(6'h21, bls_pkg::ST_NORMAL);
    trip(6'h00, bls_pkg::ST_HOSTSD);
    do_reset();
    access(1'b1, 16'h9c98, 16'h0001);
    access(1'b1, 16'h9caf, 16'h0000);
    trip(6'h00, bls_pkg::ST_POWEROFF);
    check("device_off", 16'h0001, {15'h0000, device_off});
    end_of_test();
  end
endmodule : test_backup_load_shutdown_sequencer

`default_nettype wire

// file: verilog/bls_pkg.sv
package bls_pkg;

  // ==========================================================================
  // Register offsets (holding register addresses)
  // ==========================================================================
  localparam logic [15:0] SWITCH_OFF_OUT_TIME_OFS   = 16'h9c62;
  localparam logic [15:0] FORCE_HOST_SHUTDOWN_OFS   = 16'h9c69;
  localparam logic [15:0] BACKUP_DISABLE_ENABLE_OFS = 16'h9c98;
  localparam logic [15:0] BUFFERING_TIME_OFS        = 16'h9ca8;
  localparam logic [15:0] HOST_SHUTDOWN_TIME_OFS    = 16'h9caf;
  localparam logic [15:0] LOAD_SHUTDOWN_COMMAND_OFS = 16'h9cc5;
  localparam logic [15:0] LOAD_OFF_TIMEOUT_OFS      = 16'h9cc7;

  // ==========================================================================
  // Command values and reset values
  // ==========================================================================
  localparam logic [15:0] LOAD_OFF_CMD       = 16'd32001;
  localparam logic [15:0] LOAD_ON_CMD        = 16'd32000;
  localparam logic [15:0] FORCE_CMD          = 16'h0001;
  localparam logic [15:0] HOST_TIME_RST      = 16'd60;
  localparam logic [15:0] SWITCH_OFF_RST     = 16'd20;
  localparam logic [15:0] BUFFER_TIME_RST    = 16'h0000;
  localparam logic [15:0] BACKUP_EN_RST      = 16'h0000;
  localparam logic [15:0] LOAD_TIMEOUT_RST   = 16'h0000;
  localparam logic [15:0] ZERO16             = 16'h0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          TICK_PERIOD_S  = 1;
  localparam int          TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
  localparam int          FLICKER_MS     = 100;
  localparam int          FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;

  // Selector position durations in seconds (0.5 min rounds to 30 s)
  localparam logic [15:0] SEL_SEC_1 = 16'd30;
  localparam logic [15:0] SEL_SEC_2 = 16'd120;
  localparam logic [15:0] SEL_SEC_3 = 16'd300;
  localparam logic [15:0] SEL_SEC_4 = 16'd600;
  localparam logic [15:0] SEL_SEC_5 = 16'd900;
  localparam logic [15:0] SEL_SEC_6 = 16'd1200;
  localparam logic [15:0] SEL_SEC_7 = 16'd1800;
  localparam logic [15:0] SEL_SEC_8 = 16'd2700;
  localparam logic [15:0] SEL_SEC_9 = 16'd3600;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_NORMAL  = 6'b00_0001,
    ST_BUFFER  = 6'b00_0010,
    ST_HOSTSD  = 6'b00_0100,
    ST_OUTOFF  = 6'b00_1000,
    ST_STEP4   = 6'b01_0000,
    ST_POWEROFF= 6'b10_0000
  } bls_state_type;

  typedef struct packed {
    logic        mains_ok;
    logic        batt_low;
    logic        charge_low;
    logic        capacity_set;
    logic        cutoff;
    logic        remote_closed;
  } bls_sense_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bls_reg_req_type;

endpackage : bls_pkg

// file: verilog/bls_sequencer.sv
// Overview of operation
// - Write 32001 to load command: load off, command reads back 1.
// - Diagnostic indicator flickers while load is held off by command.
// - Write 32000 to load command: load on, command reads back 0.
// - Non-zero load-off timeout turns load back on after that time.
// - Permanent output on except in power-off; dynamic output set by network commands.
// - Mains loss starts buffering timer from ten-position selector.
// - Selector position 0: buffer with no time limit until cutoff.
// - Buffering time also settable by holding register.
// - Enable register zero: always back up; contact drives fast charge.
// - Enable register one: contact open disables, closed permits backup.
// - Backup disabled, host time zero: turn off at mains loss.
// - Backup disabled, host time non-zero: mains loss starts at step two.
// - Host time non-zero runs four-step sequence from mains loss.
// - Mains return during buffering abandons shutdown, resumes charging.
// - Buffering time zero: buffering ends only on mains return, battery limits or a force write.
// - Buffering expiry: step two if host time set, else turn off.
// - Low battery, low charge with capacity, or force write while buffering: step two if host time set, else turn off.
// - Step two start signals host shutdown; mains return ignored.
// - Step two lasts host shutdown time, default 60 s, then step three.
// - Step three holds load off for switch-off time, default 20 s.
// - Step four: power down without mains, else re-enable load.
// - Battery below deep-discharge cutoff switches the device off.
`timescale 1ns/1ps
`default_nettype none

module bls_sequencer (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Register access
  input  wire bls_pkg::bls_reg_req_type reg_req,
  output logic [15:0]                   reg_rdata,
  output logic                          reg_ack,
  // Field sense inputs
  input  wire bls_pkg::bls_sense_type   sense,
  input  wire logic [3:0]               buffer_selector,
  input  wire logic                     selector_fitted,
  input  wire logic                     dyn_out_cmd,
  // Power and status outputs
  output logic                          permanent_out_on,
  output logic                          dynamic_out_on,
  output logic                          backup_active,
  output logic                          fast_charge_en,
  output logic                          host_shutdown_req,
  output logic                          device_off,
  output logic                          diagnostic_indicator,
  output bls_pkg::bls_state_type        seq_state
);

  // ==========================================================================
  // Holding registers
  // ==========================================================================
  logic [15:0] switch_off_out_time_ff;
  logic [15:0] backup_disable_enable_ff;
  logic [15:0] buffering_time_ff;
  logic [15:0] host_shutdown_time_ff;
  logic [15:0] load_off_timeout_ff;
  logic        load_cmd_off_ff;
  logic        force_ff;
  logic        force_wr;
  logic        load_timeout_hit;
  logic        load_cmd_wr;
  logic        load_off_wr;
  logic        load_on_wr;

  // Command words act only on their exact value; anything else is dropped
  assign force_wr    = reg_req.wr
                       && reg_req.addr == bls_pkg::FORCE_HOST_SHUTDOWN_OFS
                       && reg_req.wdata == bls_pkg::FORCE_CMD;
  assign load_cmd_wr = reg_req.wr
                       && reg_req.addr == bls_pkg::LOAD_SHUTDOWN_COMMAND_OFS;
  assign load_off_wr = load_cmd_wr && reg_req.wdata == bls_pkg::LOAD_OFF_CMD;
  assign load_on_wr  = load_cmd_wr && reg_req.wdata == bls_pkg::LOAD_ON_CMD;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      switch_off_out_time_ff   <= bls_pkg::SWITCH_OFF_RST;
      backup_disable_enable_ff <= bls_pkg::BACKUP_EN_RST;
      buffering_time_ff        <= bls_pkg::BUFFER_TIME_RST;
      host_shutdown_time_ff    <= bls_pkg::HOST_TIME_RST;
      load_off_timeout_ff      <= bls_pkg::LOAD_TIMEOUT_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == bls_pkg::SWITCH_OFF_OUT_TIME_OFS) begin
        switch_off_out_time_ff <= reg_req.wdata;
      end else if (reg_req.addr == bls_pkg::BACKUP_DISABLE_ENABLE_OFS) begin
        backup_disable_enable_ff <= reg_req.wdata;
      end else if (reg_req.addr == bls_pkg::BUFFERING_TIME_OFS) begin
        buffering_time_ff <= reg_req.wdata;
      end else if (reg_req.addr == bls_pkg::HOST_SHUTDOWN_TIME_OFS) begin
        host_shutdown_time_ff <= reg_req.wdata;
      end else if (reg_req.addr == bls_pkg::LOAD_OFF_TIMEOUT_OFS) begin
        load_off_timeout_ff <= reg_req.wdata;
      end
    end
  end

  // Load command: a write wins over the timeout expiring in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      load_cmd_off_ff <= 1'b0;
    end else if (load_off_wr) begin
      load_cmd_off_ff <= 1'b1;
    end else if (load_on_wr) begin
      load_cmd_off_ff <= 1'b0;
    end else if (load_timeout_hit) begin
      load_cmd_off_ff <= 1'b0;
    end
  end

  // Force request sticks until consumed; a new write wins over the consume
  logic force_consume;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      force_ff <= 1'b0;
    end else if (force_wr) begin
      force_ff <= 1'b1;
    end else if (force_consume) begin
      force_ff <= 1'b0;
    end
  end

  // Read path, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= bls_pkg::ZERO16;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_req.rd || reg_req.wr;
      if (!reg_req.rd) begin
        reg_rdata <= reg_rdata;
      end else if (reg_req.addr == bls_pkg::SWITCH_OFF_OUT_TIME_OFS) begin
        reg_rdata <= switch_off_out_time_ff;
      end else if (reg_req.addr == bls_pkg::FORCE_HOST_SHUTDOWN_OFS) begin
        reg_rdata <= {15'h0000, force_ff};
      end else if (reg_req.addr == bls_pkg::BACKUP_DISABLE_ENABLE_OFS) begin
        reg_rdata <= backup_disable_enable_ff;
      end else if (reg_req.addr == bls_pkg::BUFFERING_TIME_OFS) begin
        reg_rdata <= buffering_time_ff;
      end else if (reg_req.addr == bls_pkg::HOST_SHUTDOWN_TIME_OFS) begin
        reg_rdata <= host_shutdown_time_ff;
      end else if (reg_req.addr == bls_pkg::LOAD_SHUTDOWN_COMMAND_OFS) begin
        reg_rdata <= {15'h0000, load_cmd_off_ff};
      end else if (reg_req.addr == bls_pkg::LOAD_OFF_TIMEOUT_OFS) begin
        reg_rdata <= load_off_timeout_ff;
      end else begin
        reg_rdata <= bls_pkg::ZERO16;
      end
    end
  end

  // ==========================================================================
  // One-second tick
  // ==========================================================================
  // Free-running, so a step of N s ends between N-1 and N s
  logic [26:0] tick_cnt_ff;
  logic        tick;
  assign tick = tick_cnt_ff == 27'(bls_pkg::TICK_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || tick) begin
      tick_cnt_ff <= 27'h000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 27'h000_0001;
    end
  end

  // ==========================================================================
  // Load-off timeout
  // ==========================================================================
  logic [15:0] load_off_secs_ff;
  assign load_timeout_hit = load_cmd_off_ff && load_off_timeout_ff != 16'h0000
                            && load_off_secs_ff >= load_off_timeout_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !load_cmd_off_ff) begin
      load_off_secs_ff <= 16'h0000;
    end else if (tick && load_off_secs_ff != 16'hffff) begin
      load_off_secs_ff <= load_off_secs_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Buffering duration and backup permission
  // ==========================================================================
  logic [15:0] buf_secs;
  logic        backup_ok;

  // A fitted switch overrides the register; position 0 has no time limit
  always_comb begin
    if (!selector_fitted) begin
      buf_secs = buffering_time_ff;
    end else begin
      case (buffer_selector)
        4'h1:    buf_secs = bls_pkg::SEL_SEC_1;
        4'h2:    buf_secs = bls_pkg::SEL_SEC_2;
        4'h3:    buf_secs = bls_pkg::SEL_SEC_3;
        4'h4:    buf_secs = bls_pkg::SEL_SEC_4;
        4'h5:    buf_secs = bls_pkg::SEL_SEC_5;
        4'h6:    buf_secs = bls_pkg::SEL_SEC_6;
        4'h7:    buf_secs = bls_pkg::SEL_SEC_7;
        4'h8:    buf_secs = bls_pkg::SEL_SEC_8;
        4'h9:    buf_secs = bls_pkg::SEL_SEC_9;
        default: buf_secs = 16'h0000;
      endcase
    end
  end

  // Only value one turns on contact sensitivity
  assign backup_ok = (backup_disable_enable_ff != 16'h0001)
                     || sense.remote_closed;
  assign fast_charge_en = (backup_disable_enable_ff != 16'h0001)
                          && sense.remote_closed;

  // ==========================================================================
  // Shutdown sequence
  // ==========================================================================
  bls_pkg::bls_state_type state_ff;
  bls_pkg::bls_state_type nxt_state;
  logic [15:0]            step_secs_ff;
  logic                   step_entry;
  logic                   host_en;
  logic                   early_exit;

  assign host_en    = host_shutdown_time_ff != 16'h0000;
  assign early_exit = sense.batt_low
                      || (sense.charge_low && sense.capacity_set)
                      || force_ff;
  assign force_consume = state_ff == bls_pkg::ST_BUFFER && early_exit;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bls_pkg::ST_NORMAL: begin
        if (!sense.mains_ok) begin
          if (backup_ok) begin
            nxt_state = bls_pkg::ST_BUFFER;
          end else if (host_en) begin
            nxt_state = bls_pkg::ST_HOSTSD;
          end else begin
            nxt_state = bls_pkg::ST_POWEROFF;
          end
        end
      end
      bls_pkg::ST_BUFFER: begin
        if (sense.mains_ok) begin
          nxt_state = bls_pkg::ST_NORMAL;
        end else if (early_exit) begin
          nxt_state = host_en ? bls_pkg::ST_HOSTSD
                              : bls_pkg::ST_POWEROFF;
        end else if (buf_secs != 16'h0000 && step_secs_ff >= buf_secs) begin
          nxt_state = host_en ? bls_pkg::ST_HOSTSD
                              : bls_pkg::ST_POWEROFF;
        end
      end
      bls_pkg::ST_HOSTSD: begin
        if (step_secs_ff >= host_shutdown_time_ff) begin
          nxt_state = bls_pkg::ST_OUTOFF;
        end
      end
      bls_pkg::ST_OUTOFF: begin
        if (step_secs_ff >= switch_off_out_time_ff) begin
          nxt_state = bls_pkg::ST_STEP4;
        end
      end
      bls_pkg::ST_STEP4: begin
        nxt_state = sense.mains_ok ? bls_pkg::ST_NORMAL
                                   : bls_pkg::ST_POWEROFF;
      end
      bls_pkg::ST_POWEROFF: begin
        // Leaves for normal as soon as mains returns
        if (sense.mains_ok) begin
          nxt_state = bls_pkg::ST_NORMAL;
        end
      end
      default: nxt_state = bls_pkg::ST_NORMAL;
    endcase
    // Deep discharge overrides every step that runs from battery
    if (sense.cutoff && !sense.mains_ok) begin
      nxt_state = bls_pkg::ST_POWEROFF;
    end
  end

  assign step_entry = nxt_state != state_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= bls_pkg::ST_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Restarts on every step change and saturates instead of wrapping
  always_ff @(posedge sys_clk) begin
    if (!rst_n || step_entry) begin
      step_secs_ff <= 16'h0000;
    end else if (tick && step_secs_ff != 16'hffff) begin
      step_secs_ff <= step_secs_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Indicator flicker
  // ==========================================================================
  // Starts dark; first toggle one flicker period after the off command
  logic [23:0] flick_cnt_ff;
  logic        flick_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !load_cmd_off_ff) begin
      flick_cnt_ff <= 24'h00_0000;
      flick_ff     <= 1'b0;
    end else if (flick_cnt_ff == 24'(bls_pkg::FLICKER_CYCLES - 1)) begin
      flick_cnt_ff <= 24'h00_0000;
      flick_ff     <= ~flick_ff;
    end else begin
      flick_cnt_ff <= flick_cnt_ff + 24'h00_0001;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic outputs_live;

  // Permanent output drops only once the device has powered itself down
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outputs_live <= 1'b0;
    end else begin
      outputs_live <= state_ff != bls_pkg::ST_POWEROFF;
    end
  end

  // Dynamic output is the one that a command or step three can cut
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dynamic_out_on <= 1'b0;
    end else begin
      dynamic_out_on <= dyn_out_cmd && !load_cmd_off_ff
                        && state_ff != bls_pkg::ST_OUTOFF
                        && state_ff != bls_pkg::ST_POWEROFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      backup_active     <= 1'b0;
      host_shutdown_req <= 1'b0;
      device_off        <= 1'b0;
    end else begin
      backup_active     <= state_ff == bls_pkg::ST_BUFFER;
      host_shutdown_req <= state_ff == bls_pkg::ST_HOSTSD;
      device_off        <= state_ff == bls_pkg::ST_POWEROFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      diagnostic_indicator <= 1'b0;
    end else begin
      diagnostic_indicator <= flick_ff;
    end
  end

  assign permanent_out_on = outputs_live;
  assign seq_state        = state_ff;

endmodule : bls_sequencer

`default_nettype wire
